// *** hw/hdc_defs.vh ***
// Constants of the hand dryer controller: offsets, fields, resets, timing.
`ifndef HDC_DEFS_VH
`define HDC_DEFS_VH

// Clock rates in MHz.
`define HDC_CLK_MHZ 250
`define HDC_OSC_MHZ 20

// Register offsets (byte addresses).
`define HDC_OFF_CTRL 8'h00
`define HDC_OFF_STATUS 8'h04
`define HDC_OFF_MASK 8'h08
`define HDC_OFF_STATE 8'h0C
`define HDC_OFF_TEMP 8'h10
`define HDC_OFF_THRESH 8'h14
`define HDC_OFF_WDT_KICK 8'h18
`define HDC_OFF_OPT_WDT 8'hC0
`define HDC_OFF_OPT_SUPPLY 8'hC1
`define HDC_OFF_OPT_OSC 8'hC2
`define HDC_OFF_OPT_DEBUG 8'hC3

// Option byte contents.
`define HDC_OPT_WDT_VAL 8'hEF
`define HDC_OPT_SUPPLY_VAL 8'hE7
`define HDC_OPT_OSC_VAL 8'hF9
`define HDC_OPT_DEBUG_VAL 8'h85
`define HDC_OPT_WDT_EN_BIT 4

// Control fields and reset value.
`define HDC_CTRL_IRQ_EN 0
`define HDC_CTRL_RESET 2'h3
`define HDC_CTRL_SAMPLE_EN 1

// Status and mask fields.
`define HDC_EV_ARRIVE 0
`define HDC_EV_LEAVE 1
`define HDC_EV_CONV 2
`define HDC_EV_WDT 3
`define HDC_EV_W 4

// Temperature scale: millivolts per degree, offset, threshold degrees.
`define HDC_MV_PER_DEG 10
`define HDC_MV_OFFSET 500
`define HDC_THRESH_DEG 20
`define HDC_VREF_MV 5000
`define HDC_ADC_W 10
`define HDC_THRESH_MV (`HDC_MV_OFFSET + `HDC_MV_PER_DEG * `HDC_THRESH_DEG)
`define HDC_THRESH_CODE ((`HDC_THRESH_MV * 1024) / `HDC_VREF_MV)

// Reading refresh interval while a hand is present.
`define HDC_SAMPLE_US 100
`define HDC_SAMPLE_CYC (`HDC_SAMPLE_US * `HDC_CLK_MHZ)

// Watchdog counter width.
`define HDC_WDT_W 16

`endif

// *** hw/hdc_top.v ***
// Hand dryer controller: presence input, temperature compare, drive outputs.
`timescale 1ns/1ps
`default_nettype none
`include "hdc_defs.vh"

// Behaviour
// - Fan drive output is high while a hand is detected.
// - Heater is high with a hand present and temperature at or below 20 C.
// - Heater is low with a hand present and temperature above 20 C.
// - With no hand, fan and heater are both low whatever the temperature.
// - The presence input is enabled after power on and its events acted on.
// - Sensor voltage is 10 mV per degree plus 500 mV; 20 C is 700 mV.
// - Fan and heater outputs are plain on/off levels, never modulated.
// - The watchdog is disabled by its option byte and does not count.
// - Logic is clocked at 250 MHz; the fast internal oscillator runs at 20 MHz.
// - Supply-level reset holds the block until the supply is good.
module hdc_top #(
  parameter [31:0] SAMPLE_CYC = `HDC_SAMPLE_CYC
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Supply monitor pin, high once the supply passes the detection level.
  input wire supply_ok,
  // Presence sensor pin, low while a hand is sensed.
  input wire presence_irq_in_n,
  // Converter for the temperature channel, same clock.
  output wire adc_start,
  input wire adc_done,
  input wire [`HDC_ADC_W-1:0] adc_result,
  // Load drives.
  output reg fan_drive_out,
  output reg heater_drive_out,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Interrupt.
  output wire irq
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_GAP = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;
  localparam integer THRESH_INIT = `HDC_THRESH_CODE;

  // Synchronisers for the pins.
  reg pres_meta;
  reg pres_sync_n;
  reg sup_meta;
  reg sup_sync;

  // Registers.
  reg [1:0] ctrl;
  reg [`HDC_EV_W-1:0] status;
  reg [`HDC_EV_W-1:0] mask;
  reg [`HDC_ADC_W-1:0] temp_code;
  reg [`HDC_ADC_W-1:0] thresh;
  reg temp_valid;
  reg present_q;

  // Converter sequencing.
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] gap_cnt;
  reg [`HDC_WDT_W-1:0] wdt_cnt;

  wire rst;
  wire present;
  wire cold;
  wire wdt_en;
  wire [`HDC_EV_W-1:0] events;
  wire [`HDC_EV_W-1:0] w1c;
  wire wr_ctrl;
  wire wr_status;
  wire wr_mask;
  wire wr_thresh;
  wire wr_kick;
  wire [7:0] opt_wdt;
  wire wdt_wrap;
  wire [31:0] thresh_init;
  wire ev_arrive;
  wire ev_leave;
  wire ev_conv;
  genvar gi;

  // The supply monitor pin passes two flops before it may hold the reset.
  always @(posedge clk) begin
    if (!resetn) begin
      sup_meta <= 1'b0;
      sup_sync <= 1'b0;
    end else begin
      sup_meta <= supply_ok;
      sup_sync <= sup_meta;
    end
  end

  // Everything but the supply synchroniser stays in reset while low.
  assign rst = !resetn || !sup_sync;

  // The presence pin idles high, so its synchroniser resets to high.
  always @(posedge clk) begin
    if (rst) begin
      pres_meta <= 1'b1;
      pres_sync_n <= 1'b1;
    end else begin
      pres_meta <= presence_irq_in_n;
      pres_sync_n <= pres_meta;
    end
  end

  // A low level on the sensor means a hand; gated by the input enable.
  assign present = ctrl[`HDC_CTRL_IRQ_EN] && !pres_sync_n;

  always @(posedge clk) begin
    if (rst) begin
      present_q <= 1'b0;
    end else begin
      present_q <= present;
    end
  end

  // Threshold in converter codes of the sensor scale.
  assign cold = temp_valid && (temp_code <= thresh);

  // Outputs are plain levels taken straight from the decision.
  always @(posedge clk) begin
    if (rst) begin
      fan_drive_out <= 1'b0;
      heater_drive_out <= 1'b0;
    end else begin
      fan_drive_out <= present;
      heater_drive_out <= present && cold;
    end
  end

  // Sampling sequencer: request readings only while a hand is there.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (present && ctrl[`HDC_CTRL_SAMPLE_EN]) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (adc_done) begin
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (!present || !ctrl[`HDC_CTRL_SAMPLE_EN]) begin
          next_state = ST_IDLE;
        end else if (gap_cnt == 32'h0000_0000) begin
          next_state = ST_CONV;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // A request during reset would leave the converter answering no one.
  assign adc_start = !rst && (state != ST_CONV) && (next_state == ST_CONV);

  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      gap_cnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (state == ST_CONV) begin
        gap_cnt <= SAMPLE_CYC - 32'h0000_0001;
      end else if (gap_cnt != 32'h0000_0000) begin
        gap_cnt <= gap_cnt - 32'h0000_0001;
      end
    end
  end

  // A result is accepted only when one was requested.
  always @(posedge clk) begin
    if (rst) begin
      temp_code <= {`HDC_ADC_W{1'b0}};
      temp_valid <= 1'b0;
    end else if (state == ST_CONV && adc_done) begin
      temp_code <= adc_result;
      temp_valid <= 1'b1;
    end
  end

  // The watchdog counts only when its option byte enables it.
  assign opt_wdt = `HDC_OPT_WDT_VAL;
  assign wdt_en = opt_wdt[`HDC_OPT_WDT_EN_BIT];
  assign wdt_wrap = wdt_en && (&wdt_cnt);

  always @(posedge clk) begin
    if (rst || wr_kick) begin
      wdt_cnt <= {`HDC_WDT_W{1'b0}};
    end else if (wdt_en) begin
      wdt_cnt <= wdt_cnt + {{(`HDC_WDT_W-1){1'b0}}, 1'b1};
    end
  end

  // Register decode.
  assign wr_ctrl = reg_wr && (reg_addr == `HDC_OFF_CTRL);
  assign wr_status = reg_wr && (reg_addr == `HDC_OFF_STATUS);
  assign wr_mask = reg_wr && (reg_addr == `HDC_OFF_MASK);
  assign wr_thresh = reg_wr && (reg_addr == `HDC_OFF_THRESH);
  assign wr_kick = reg_wr && (reg_addr == `HDC_OFF_WDT_KICK);

  // Events of this cycle; a new event outranks a clearing write.
  assign ev_arrive = !present_q && present;
  assign ev_leave = present_q && !present;
  assign ev_conv = (state == ST_CONV) && adc_done;
  assign events = {wdt_wrap, ev_conv, ev_leave, ev_arrive};
  assign w1c = wr_status ? reg_wdata[`HDC_EV_W-1:0] : {`HDC_EV_W{1'b0}};
  assign thresh_init = THRESH_INIT;

  // Each status bit is sticky: its event sets it, a written one clears it.
  generate
    for (gi = 0; gi < `HDC_EV_W; gi = gi + 1) begin : g_status
      always @(posedge clk) begin
        if (rst) begin
          status[gi] <= 1'b0;
        end else if (events[gi]) begin
          status[gi] <= 1'b1;
        end else if (w1c[gi]) begin
          status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      ctrl <= `HDC_CTRL_RESET;
      mask <= {`HDC_EV_W{1'b0}};
      thresh <= thresh_init[`HDC_ADC_W-1:0];
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata[1:0];
      end
      if (wr_mask) begin
        mask <= reg_wdata[`HDC_EV_W-1:0];
      end
      if (wr_thresh) begin
        thresh <= reg_wdata[`HDC_ADC_W-1:0];
      end
    end
  end

  assign irq = |(status & mask);

  // Read data stand in the cycle after the strobe only.
  always @(posedge clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        `HDC_OFF_CTRL: begin
          reg_rdata <= {30'h0000_0000, ctrl};
        end
        `HDC_OFF_STATUS: begin
          reg_rdata <= {28'h000_0000, status};
        end
        `HDC_OFF_MASK: begin
          reg_rdata <= {28'h000_0000, mask};
        end
        `HDC_OFF_STATE: begin
          reg_rdata <= {28'h000_0000, temp_valid, heater_drive_out,
                        fan_drive_out, present};
        end
        `HDC_OFF_TEMP: begin
          reg_rdata <= {22'h00_0000, temp_code};
        end
        `HDC_OFF_THRESH: begin
          reg_rdata <= {22'h00_0000, thresh};
        end
        `HDC_OFF_OPT_WDT: begin
          reg_rdata <= {24'h00_0000, opt_wdt};
        end
        `HDC_OFF_OPT_SUPPLY: begin
          reg_rdata <= {24'h00_0000, `HDC_OPT_SUPPLY_VAL};
        end
        `HDC_OFF_OPT_OSC: begin
          reg_rdata <= {24'h00_0000, `HDC_OPT_OSC_VAL};
        end
        `HDC_OFF_OPT_DEBUG: begin
          reg_rdata <= {24'h00_0000, `HDC_OPT_DEBUG_VAL};
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** test/hdc_props.sv ***
// Port checker for the hand dryer controller, bound into its top module.
`timescale 1ns/1ps
`default_nettype none
module hdc_props #(
  parameter int SAMPLE_CYC = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  input wire logic supply_ok,
  // Sensor, converter and drives.
  input wire logic presence_irq_in_n,
  input wire logic adc_start,
  input wire logic adc_done,
  input wire logic [9:0] adc_result,
  input wire logic fan_drive_out,
  input wire logic heater_drive_out,
  // Register read path.
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  localparam int COLD = 143;
  logic [2:0] up;
  logic [7:0] since;
  logic busy;
  // Cycles since reset, cycles since a result, and a conversion in flight.
  // A supply loss resets the block, so it restarts these as well.
  always @(posedge clk) begin
    if (!resetn || !supply_ok) begin
      up <= 3'h0;
      since <= 8'hff;
      busy <= 1'b0;
    end else begin
      if (up != 3'h7) up <= up + 3'h1;
      if (adc_done) since <= 8'h00;
      else if (since != 8'hff) since <= since + 8'h01;
      if (adc_start) busy <= 1'b1;
      else if (adc_done) busy <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  fan_follow_a: assert property (
    up == 3'h7 |-> fan_drive_out == !$past(presence_irq_in_n, 3))
    else $error("fan does not follow the presence pin");
  heat_gate_a: assert property (
    !fan_drive_out |-> !heater_drive_out)
    else $error("heater on without a hand");
  cold_on_a: assert property (
    busy && adc_done && adc_result <= COLD
      |-> ##2 heater_drive_out == fan_drive_out)
    else $error("heater off on a cold reading");
  hot_off_a: assert property (
    busy && adc_done && adc_result > COLD |-> ##2 !heater_drive_out)
    else $error("heater on on a warm reading");
  start_pulse_a: assert property (
    adc_start |=> !adc_start)
    else $error("conversion request longer than one cycle");
  no_restart_a: assert property (
    busy |-> !adc_start)
    else $error("new request while a conversion is out");
  refresh_due_a: assert property (
    !busy && since == SAMPLE_CYC - 1 && fan_drive_out
      |-> adc_start or ##1 !fan_drive_out)
    else $error("reading not refreshed while a hand is present");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");
endmodule
bind hdc_top hdc_props #(.SAMPLE_CYC(SAMPLE_CYC)) hdc_props_i (
  .clk(clk), .resetn(resetn), .supply_ok(supply_ok),
  .presence_irq_in_n(presence_irq_in_n),
  .adc_start(adc_start), .adc_done(adc_done), .adc_result(adc_result),
  .fan_drive_out(fan_drive_out), .heater_drive_out(heater_drive_out),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// *** test/hdc_partner.sv ***
// Presence sensor and temperature converter beside the controller.
`timescale 1ns/1ps
`default_nettype none
module hdc_partner (
  // Clock.
  input wire logic clk,
  // Scene set by the bench.
  input wire logic hand,
  input wire logic [9:0] code,
  input wire logic slow,
  // Pins toward the controller.
  output logic presence_irq_in_n,
  input wire logic adc_start,
  output logic adc_done,
  output logic [9:0] adc_result
);
  int wait_n = -1;
  logic done_r = 1'b0;
  logic [9:0] res_r = 10'h000;
  assign presence_irq_in_n = !hand;
  assign adc_done = done_r;
  assign adc_result = res_r;
  // Result lines carry junk except in the answer cycle.
  always @(posedge clk) begin
    done_r <= 1'b0;
    res_r <= ~res_r;
    if (adc_start) wait_n <= slow ? 7 : 0;
    else if (wait_n > 0) wait_n <= wait_n - 1;
    else if (wait_n == 0) begin
      done_r <= 1'b1;
      res_r <= code;
      wait_n <= -1;
    end
  end
endmodule
`default_nettype wire

// *** test/hand_dryer_controller_tb_top.sv ***
// Self-checking testbench for the hand dryer controller.
`timescale 1ns/1ps
`default_nettype none
`include "hdc_defs.vh"
module hand_dryer_controller_tb_top;
  logic clk = 0, resetn = 0, hand = 0, slow = 0, reg_wr = 0, reg_rd = 0;
  logic adc_start, adc_done, pin_n, fan, heat, irq;
  logic [9:0] code = 10'h000, adc_result;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] opt[4] = '{8'hef, 8'he7, 8'hf9, 8'h85};
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, v;
  logic supply = 1;
  int bad_count = 0, cmp_count = 0, n, seen;
  int res_q[$];
  int lim = (500 + 10 * 20) * 1024 / 5000;
  int codes[$] = '{143, 144, 0, 1023};
  always #2 clk = ~clk;
  hdc_top #(.SAMPLE_CYC(20)) hdc_top_i (.clk(clk), .resetn(resetn),
    .supply_ok(supply), .presence_irq_in_n(pin_n), .adc_start(adc_start),
    .adc_done(adc_done), .adc_result(adc_result), .fan_drive_out(fan),
    .heater_drive_out(heat), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  hdc_partner hdc_partner_i (.clk(clk), .hand(hand), .code(code),
    .slow(slow), .presence_irq_in_n(pin_n), .adc_start(adc_start),
    .adc_done(adc_done), .adc_result(adc_result));
  // Reference heater: the fan level and the result seen two edges before.
  always @(posedge clk) begin
    res_q.push_back(adc_done ? int'(adc_result) : -1);
    if (res_q.size() > 2) begin
      seen = res_q.pop_front();
      if (seen >= 0) chk(heat, fan && (seen <= lim));
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp) bad_count++;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // The whole run needs about 1000 cycles; five times that cuts a hang.
  initial begin
    cyc(5000);
    bad_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(68));
    cyc(6);
    resetn <= 1'b1;
    // The supply synchroniser keeps the block in reset two more edges.
    cyc(2);
    for (int i = 0; i < 4; i++) begin
      rd(8'hc0 + i[7:0]);
      chk(v, {24'h00_0000, opt[i]});
    end
    wr(8'hc0, 32'h0000_0000);
    rd(8'hc0);
    chk(v, 32'h0000_00ef);
    rd(`HDC_OFF_THRESH);
    chk(v, lim);
    rd(8'h40);
    chk(v, 32'h0000_0000);
    rd(`HDC_OFF_CTRL);
    chk(v, 32'h0000_0003);
    $display("register test done");
    wr(`HDC_OFF_MASK, 32'h0000_0001);
    hand <= 1'b1;
    cyc(10);
    chk(irq, 1'b1);
    wr(`HDC_OFF_STATUS, 32'h0000_0001);
    cyc(2);
    chk(irq, 1'b0);
    wr(`HDC_OFF_MASK, 32'h0000_0000);
    hand <= 1'b0;
    cyc(12);
    wr(`HDC_OFF_STATUS, 32'h0000_000f);
    $display("interrupt test done");
    repeat (4) codes.push_back($urandom_range(1023));
    foreach (codes[i]) begin
      n = codes[(i + 1) % codes.size()];
      code <= codes[i][9:0];
      slow <= 1'($urandom_range(1));
      hand <= 1'b1;
      cyc(40);
      chk(fan, 1'b1);
      chk(heat, codes[i] <= lim);
      code <= n[9:0];
      cyc(60);
      chk(heat, n <= lim);
      hand <= 1'b0;
      cyc(10);
      chk({fan, heat}, 2'b00);
    end
    $display("drive test done");
    hand <= 1'b1;
    wr(`HDC_OFF_MASK, 32'h0000_000f);
    cyc(40);
    supply <= 1'b0;
    cyc(5);
    chk({fan, heat}, 2'b00);
    chk(irq, 1'b0);
    supply <= 1'b1;
    cyc(12);
    chk(fan, 1'b1);
    rd(`HDC_OFF_MASK);
    chk(v, 32'h0000_0000);
    hand <= 1'b0;
    cyc(10);
    chk({fan, heat}, 2'b00);
    $display("supply test done");
    wrap_up;
  end
endmodule
`default_nettype wire
